// ### rtl/mbt_pkg.sv
// Purpose: Shared constants for the memory self-test block
// Assumes: 200 MHz core clock
// Notes:   Times are kept in their own unit with derived cycle counts
package mbt_pkg;
  localparam int unsigned CLK_HZ          = 200000000;
  localparam int unsigned ADDR_LFSR_W     = 26;
  // Addresses in one full generator sequence
  localparam int unsigned ADDR_SEQ_LEN    = (32'h1 << ADDR_LFSR_W) - 32'h1;
  localparam int unsigned USER_ADDR_W     = 31;
  localparam int unsigned DATA_W          = 64;
  localparam logic [25:0] ADDR_SEED       = 26'h0000001;
  localparam logic [63:0] DATA_SEED_LO    = 64'h0000000000000001;
  localparam logic [63:0] DATA_SEED_HI    = 64'h0000000000000003;
  localparam int unsigned PASS_PERIOD_MS  = 8000;
  localparam int unsigned FAIL_STEADY_MS  = 4000;
  localparam int unsigned FAIL_BLINK_MS   = 1000;
  localparam int unsigned FAIL_BLINKS     = 4;
  localparam longint unsigned PASS_HALF_CYC =
    longint'(CLK_HZ) * longint'(PASS_PERIOD_MS) / 2000;
  localparam longint unsigned FAIL_STEADY_CYC =
    longint'(CLK_HZ) * longint'(FAIL_STEADY_MS) / 1000;
  localparam longint unsigned FAIL_HALF_CYC =
    longint'(CLK_HZ) * longint'(FAIL_BLINK_MS) / 2000;
  localparam logic [2:0]  CMD_WRITE       = 3'h0;
  localparam logic [2:0]  CMD_READ        = 3'h1;

  // 64-bit generator step shared by write and compare sides
  function automatic logic [63:0] mbt_data_step(input logic [63:0] v);
    mbt_data_step = {v[62:0], v[63] ^ v[62] ^ v[60] ^ v[59]};
  endfunction : mbt_data_step

  // 26-bit address generator step
  function automatic logic [25:0] mbt_addr_step(input logic [25:0] v);
    mbt_addr_step = {v[24:0], v[25] ^ v[5] ^ v[1] ^ v[0]};
  endfunction : mbt_addr_step
endpackage : mbt_pkg

// ### rtl/mbt_led_if.sv
// Purpose: Outcome carrier from engine to LED pattern generator
// Assumes: One clock domain
// Notes:   Outcome levels hold once set
`timescale 1ns/10ps
`default_nettype none
interface mbt_led_if;
  logic calib_busy;
  logic done;
  logic failed;
  modport engine (output calib_busy, output done, output failed);
  modport led    (input calib_busy, input done, input failed);
endinterface : mbt_led_if
`default_nettype wire

// ### rtl/mbt_led.sv
// Purpose: Status LED pattern generator
// Assumes: Cycle counts from the package
// Notes:   Counter widths fit the 8 s pattern at 200 MHz
`timescale 1ns/10ps
`default_nettype none
module mbt_led #(
  parameter longint unsigned PASS_HALF   = mbt_pkg::PASS_HALF_CYC,
  parameter longint unsigned FAIL_STEADY = mbt_pkg::FAIL_STEADY_CYC,
  parameter longint unsigned FAIL_HALF   = mbt_pkg::FAIL_HALF_CYC
) (
  input  wire logic core_clk,
  input  wire logic arst_n,
  mbt_led_if.led    st,
  output logic      led_o
);
  typedef struct packed {
    logic [31:0] cnt;
    logic [3:0]  phase;
    logic        led;
  } mbt_led_state_type;

  mbt_led_state_type s_q;
  mbt_led_state_type s_d;

  always_comb begin
    s_d = s_q;
    if (!st.done) begin
      s_d.cnt   = 32'h0;
      s_d.phase = 4'h0;
      s_d.led   = st.calib_busy;
    end else if (!st.failed) begin
      if (s_q.cnt >= 32'(PASS_HALF - 1)) begin
        s_d.cnt = 32'h0;
        s_d.led = ~s_q.led;
      end else begin
        s_d.cnt = s_q.cnt + 32'h1;
      end
    end else begin
      // Phase 0 steady on, then eight half-periods of blinking
      if (s_q.phase == 4'h0) begin
        s_d.led = 1'b1;
        if (s_q.cnt >= 32'(FAIL_STEADY - 1)) begin
          s_d.cnt   = 32'h0;
          s_d.phase = 4'h1;
          s_d.led   = 1'b0;
        end else begin
          s_d.cnt = s_q.cnt + 32'h1;
        end
      end else if (s_q.cnt >= 32'(FAIL_HALF - 1)) begin
        s_d.cnt = 32'h0;
        if (s_q.phase == 4'(2 * mbt_pkg::FAIL_BLINKS)) begin
          s_d.phase = 4'h0;
          s_d.led   = 1'b1;
        end else begin
          s_d.phase = s_q.phase + 4'h1;
          s_d.led   = ~s_q.led;
        end
      end else begin
        s_d.cnt = s_q.cnt + 32'h1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign led_o = s_q.led;

  a_led_calib: assert property (@(posedge core_clk) disable iff (!arst_n)
    (!st.done) |=> (s_q.led == $past(st.calib_busy)))
    else $error("status led does not follow calibration state");
endmodule : mbt_led
`default_nettype wire

// ### rtl/mbt_engine.sv
// Purpose: Self-checking write then read test of a memory behind a controller
// Assumes: Controller takes a command when app_rdy is high; BL4, two 128-bit words
// Notes:   Starts by itself after reset once calibration completes
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Test starts on its own after reset, needing only calibration complete.
// - Engine idles until calibration complete; never starts otherwise.
// - Write location zero first, then every address of one generator sequence.
// - Write phase ends when address generator returns to seed; read phase follows.
// - Read location zero first, then step read generator until back at seed.
// - Each valid read word is compared against the next expected-data value.
// - Any miscompare sets a sticky error, examined at finish for pass/fail.
// - LED off in reset, on in calibration, off after and during test.
// - Pass: LED blinks with eight-second period, half on.
// - Fail: four seconds on, then four one-second blinks, repeated.
// - First dip switch corrupts write data to force a failure.
// - User address: zeros, chip select, bank, row, column with low bits zero.
// - 26-bit left shift address generator, taps 25,5,1,0; both sides same.
// - Data from two 64-bit generators; write and compare pairs identical.
module mbt_engine #(
  parameter longint unsigned PASS_HALF   = mbt_pkg::PASS_HALF_CYC,
  parameter longint unsigned FAIL_STEADY = mbt_pkg::FAIL_STEADY_CYC,
  parameter longint unsigned FAIL_HALF   = mbt_pkg::FAIL_HALF_CYC,
  parameter int unsigned     SWEEP_LEN   = mbt_pkg::ADDR_SEQ_LEN
) (
  input  wire logic         core_clk,
  input  wire logic         arst_n,
  input  wire logic         calib_done,
  input  wire logic         dip_sw0,
  input  wire logic         app_rdy,
  input  wire logic         app_wdf_rdy,
  input  wire logic         rd_valid,
  input  wire logic [127:0] rd_data,
  output logic              app_en,
  output logic [2:0]        app_cmd,
  output logic [30:0]       app_addr,
  output logic              app_wdf_wren,
  output logic              app_wdf_end,
  output logic [127:0]      app_wdf_data,
  output logic              test_done,
  output logic              test_fail,
  output logic              status_led
);
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_WCMD  = 3'b001,
    ST_WDAT  = 3'b010,
    ST_RCMD  = 3'b011,
    ST_RWAIT = 3'b100,
    ST_DONE  = 3'b101
  } mbt_state_type;

  typedef struct packed {
    mbt_state_type st;
    logic          first;
    logic          beat;
    logic [25:0]   waddr;
    logic [25:0]   raddr;
    logic [25:0]   wcnt;
    logic [25:0]   rcnt;
    logic [63:0]   wd_lo;
    logic [63:0]   wd_hi;
    logic [63:0]   ed_lo;
    logic [63:0]   ed_hi;
    logic [31:0]   pend;
    logic          err;
    logic          en;
    logic [2:0]    cmd;
    logic [30:0]   addr;
    logic          wren;
    logic          wend;
    logic [127:0]  wdata;
    logic          done;
  } mbt_eng_state_type;

  mbt_eng_state_type s_q;
  mbt_eng_state_type s_d;
  mbt_led_if         led_bus ();

  // Map a generator value onto the controller's user address
  function automatic logic [30:0] mbt_user_addr(input logic [25:0] g, input logic zero);
    logic [25:0] v;
    v = zero ? 26'h0 : g;
    mbt_user_addr = {3'h0, v[25], v[24:22], v[21:8], v[7:0], 2'h0};
  endfunction : mbt_user_addr

  logic         cmd_take;
  logic         last_w;
  logic         last_r;
  logic [127:0] exp_word;

  assign cmd_take = s_q.en && app_rdy;
  // Sweep ends back at the seed, or earlier when SWEEP_LEN is shorter
  assign last_w   = !s_q.first
                    && ((mbt_pkg::mbt_addr_step(s_q.waddr) == mbt_pkg::ADDR_SEED)
                    || (s_q.wcnt == 26'(SWEEP_LEN - 1)));
  assign last_r   = !s_q.first
                    && ((mbt_pkg::mbt_addr_step(s_q.raddr) == mbt_pkg::ADDR_SEED)
                    || (s_q.rcnt == 26'(SWEEP_LEN - 1)));
  assign exp_word = {s_q.ed_hi, s_q.ed_lo};

  always_comb begin
    s_d = s_q;
    if (app_wdf_rdy && s_q.wren) begin
      s_d.wren = 1'b0;
      s_d.wend = 1'b0;
    end
    // Compare every returned word while reads are in flight
    if (rd_valid) begin
      if (rd_data != exp_word) begin
        s_d.err = 1'b1;
      end
      s_d.ed_lo = mbt_pkg::mbt_data_step(s_q.ed_lo);
      s_d.ed_hi = mbt_pkg::mbt_data_step(s_q.ed_hi);
      s_d.pend  = s_q.pend - 32'h1;
    end
    case (s_q.st)
      ST_IDLE: begin
        if (calib_done) begin
          s_d.st    = ST_WCMD;
          s_d.first = 1'b1;
          s_d.en    = 1'b1;
          s_d.cmd   = mbt_pkg::CMD_WRITE;
          s_d.addr  = mbt_user_addr(s_q.waddr, 1'b1);
        end
      end
      ST_WCMD: begin
        if (cmd_take) begin
          s_d.en    = 1'b0;
          s_d.st    = ST_WDAT;
          s_d.beat  = 1'b0;
          s_d.wren  = 1'b1;
          s_d.wdata = {s_q.wd_hi, s_q.wd_lo ^ {63'h0, dip_sw0}};
          s_d.wd_lo = mbt_pkg::mbt_data_step(s_q.wd_lo);
          s_d.wd_hi = mbt_pkg::mbt_data_step(s_q.wd_hi);
        end
      end
      ST_WDAT: begin
        if (app_wdf_rdy && s_q.wren) begin
          if (!s_q.beat) begin
            s_d.beat  = 1'b1;
            s_d.wren  = 1'b1;
            s_d.wend  = 1'b1;
            s_d.wdata = {s_q.wd_hi, s_q.wd_lo ^ {63'h0, dip_sw0}};
            s_d.wd_lo = mbt_pkg::mbt_data_step(s_q.wd_lo);
            s_d.wd_hi = mbt_pkg::mbt_data_step(s_q.wd_hi);
          end else if (last_w) begin
            s_d.st    = ST_RCMD;
            s_d.first = 1'b1;
            s_d.raddr = mbt_pkg::ADDR_SEED;
            s_d.rcnt  = 26'h0;
            s_d.ed_lo = mbt_pkg::DATA_SEED_LO;
            s_d.ed_hi = mbt_pkg::DATA_SEED_HI;
            s_d.pend  = 32'h0;
            s_d.en    = 1'b1;
            s_d.cmd   = mbt_pkg::CMD_READ;
            s_d.addr  = mbt_user_addr(s_q.raddr, 1'b1);
          end else begin
            if (!s_q.first) begin
              s_d.waddr = mbt_pkg::mbt_addr_step(s_q.waddr);
              s_d.wcnt  = s_q.wcnt + 26'h1;
            end
            s_d.first = 1'b0;
            s_d.st    = ST_WCMD;
            s_d.en    = 1'b1;
            s_d.addr  = mbt_user_addr(s_q.first ? s_q.waddr
                                      : mbt_pkg::mbt_addr_step(s_q.waddr), 1'b0);
          end
        end
      end
      ST_RCMD: begin
        if (cmd_take) begin
          s_d.pend = s_d.pend + 32'h2;
          if (last_r) begin
            s_d.en = 1'b0;
            s_d.st = ST_RWAIT;
          end else begin
            if (!s_q.first) begin
              s_d.raddr = mbt_pkg::mbt_addr_step(s_q.raddr);
              s_d.rcnt  = s_q.rcnt + 26'h1;
            end
            s_d.first = 1'b0;
            s_d.addr  = mbt_user_addr(s_q.first ? s_q.raddr
                                      : mbt_pkg::mbt_addr_step(s_q.raddr), 1'b0);
          end
        end
      end
      ST_RWAIT: begin
        if (s_d.pend == 32'h0) begin
          s_d.st = ST_DONE;
        end
      end
      ST_DONE: begin
        s_d.st = ST_DONE;
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
    s_d.done = (s_d.st == ST_DONE);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q       <= '0;
      s_q.st    <= ST_IDLE;
      s_q.waddr <= mbt_pkg::ADDR_SEED;
      s_q.raddr <= mbt_pkg::ADDR_SEED;
      s_q.wd_lo <= mbt_pkg::DATA_SEED_LO;
      s_q.wd_hi <= mbt_pkg::DATA_SEED_HI;
      s_q.ed_lo <= mbt_pkg::DATA_SEED_LO;
      s_q.ed_hi <= mbt_pkg::DATA_SEED_HI;
      s_q.cmd   <= mbt_pkg::CMD_WRITE;
    end else begin
      s_q <= s_d;
    end
  end

  assign led_bus.calib_busy = (s_q.st == ST_IDLE) && !calib_done;
  assign led_bus.done       = s_q.done;
  assign led_bus.failed     = s_q.err;

  mbt_led #(
    .PASS_HALF   (PASS_HALF),
    .FAIL_STEADY (FAIL_STEADY),
    .FAIL_HALF   (FAIL_HALF)
  ) u_led (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .st       (led_bus),
    .led_o    (status_led)
  );

  assign app_en       = s_q.en;
  assign app_cmd      = s_q.cmd;
  assign app_addr     = s_q.addr;
  assign app_wdf_wren = s_q.wren;
  assign app_wdf_end  = s_q.wend;
  assign app_wdf_data = s_q.wdata;
  assign test_done    = s_q.done;
  assign test_fail    = s_q.err;

  a_idle_until_cal: assert property (@(posedge core_clk) disable iff (!arst_n)
    (!calib_done && s_q.st == ST_IDLE) |=> (s_q.st == ST_IDLE && !s_q.en))
    else $error("engine left idle before calibration");
  a_first_addr_zero: assert property (@(posedge core_clk) disable iff (!arst_n)
    (s_q.st == ST_IDLE && calib_done) |=> (app_en && app_addr == 31'h0))
    else $error("first write is not location zero");
  a_addr_low_zero: assert property (@(posedge core_clk) disable iff (!arst_n)
    app_en |-> (app_addr[30:28] == 3'h0 && app_addr[1:0] == 2'h0))
    else $error("user address fixed bits not zero");
  a_err_sticky: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_q.err |=> s_q.err)
    else $error("error flag cleared");
  a_miscompare_flag: assert property (@(posedge core_clk) disable iff (!arst_n)
    (rd_valid && rd_data != exp_word) |=> s_q.err)
    else $error("miscompare not latched");
  a_read_restart: assert property (@(posedge core_clk) disable iff (!arst_n)
    ($rose(s_q.st == ST_RCMD) && s_q.first) |-> (s_q.raddr == mbt_pkg::ADDR_SEED
      && s_q.ed_lo == mbt_pkg::DATA_SEED_LO && app_addr == 31'h0))
    else $error("read phase did not restart from seed");
  a_wdata_corrupt: assert property (@(posedge core_clk) disable iff (!arst_n)
    (s_q.st == ST_WCMD && cmd_take)
      |=> (app_wdf_data[0] == ($past(s_q.wd_lo[0]) ^ $past(dip_sw0))))
    else $error("write data corruption wrong");
  a_done_holds: assert property (@(posedge core_clk) disable iff (!arst_n)
    test_done |=> (test_done && !app_en))
    else $error("test left done state");
endmodule : mbt_engine
`default_nettype wire

// ### bench/mbt_ctrl_model.sv
// Purpose: Behavioural memory controller user side for the self-test bench
// Assumes: Level handshakes sampled on the rising clock edge
// Notes:   Stores written beats and returns both beats, in order, for each read
`timescale 1ns/10ps
`default_nettype none
module mbt_ctrl_model #(
  parameter int STAGE_CYC = 6
) (
  input  wire logic         core_clk,
  input  wire logic         arst_n,
  input  wire logic         calib_go,
  input  wire logic         slow,
  input  wire logic         app_en,
  input  wire logic [2:0]   app_cmd,
  input  wire logic [30:0]  app_addr,
  input  wire logic         app_wdf_wren,
  input  wire logic         app_wdf_end,
  input  wire logic [127:0] app_wdf_data,
  output logic              calib_done,
  output logic              app_rdy,
  output logic              app_wdf_rdy,
  output logic              rd_valid,
  output logic [127:0]      rd_data
);
  localparam int BURST_LEN = 4;
  localparam int CAS_LAT   = 3;
  localparam int ADD_LAT   = 0;
  logic [2:0]  stage_q;
  logic [7:0]  cnt_q;
  logic [31:0] tick_q;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage_q     <= 3'h0;
      cnt_q       <= 8'h00;
      tick_q      <= 32'h00000000;
      calib_done  <= 1'b0;
      app_rdy     <= 1'b0;
      app_wdf_rdy <= 1'b0;
    end else begin
      tick_q <= tick_q + 32'h00000001;
      // Four calibration stages, then completion is raised and held
      if (calib_go && stage_q != 3'h4) begin
        if (cnt_q == 8'(STAGE_CYC - 1)) begin
          cnt_q   <= 8'h00;
          stage_q <= stage_q + 3'h1;
        end else begin
          cnt_q <= cnt_q + 8'h01;
        end
      end
      calib_done  <= (stage_q == 3'h4);
      // Two beats per command as burst length four delivers
      app_rdy     <= (stage_q == 3'h4) && (!slow || tick_q[1:0] != 2'h0);
      app_wdf_rdy <= (stage_q == 3'h4) && (!slow || tick_q[0]);
    end
  end

  logic [30:0]  mem_addr [0:31];
  logic [127:0] mem_b0   [0:31];
  logic [127:0] mem_b1   [0:31];
  logic [30:0]  rq       [0:31];
  logic [4:0]   mem_n_q;
  logic [4:0]   rq_w_q;
  logic [4:0]   rq_r_q;
  logic [30:0]  wa_q;
  logic         rbeat_q;

  // Stored beat for an address, zero if it was never written
  function automatic logic [127:0] mem_lookup(input logic [30:0] a, input logic second);
    mem_lookup = 128'h0;
    for (int i = 0; i < 32; i++) begin
      if (5'(i) < mem_n_q && mem_addr[i] == a) begin
        mem_lookup = second ? mem_b1[i] : mem_b0[i];
      end
    end
  endfunction : mem_lookup

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_n_q  <= 5'h00;
      rq_w_q   <= 5'h00;
      rq_r_q   <= 5'h00;
      wa_q     <= 31'h00000000;
      rbeat_q  <= 1'b0;
      rd_valid <= 1'b0;
      rd_data  <= 128'h0;
    end else begin
      if (app_en && app_rdy) begin
        if (app_cmd == mbt_pkg::CMD_READ) begin
          rq[rq_w_q] <= app_addr;
          rq_w_q     <= rq_w_q + 5'h01;
        end else begin
          wa_q <= app_addr;
        end
      end
      // Two beats per write command as burst length four delivers
      if (app_wdf_wren && app_wdf_rdy) begin
        mem_addr[mem_n_q] <= wa_q;
        if (app_wdf_end) begin
          mem_b1[mem_n_q] <= app_wdf_data;
          mem_n_q         <= mem_n_q + 5'h01;
        end else begin
          mem_b0[mem_n_q] <= app_wdf_data;
        end
      end
      // One returned word per cycle while reads are queued
      if (rq_r_q != rq_w_q) begin
        rd_valid <= 1'b1;
        rd_data  <= mem_lookup(rq[rq_r_q], rbeat_q);
        rbeat_q  <= ~rbeat_q;
        if (rbeat_q) begin
          rq_r_q <= rq_r_q + 5'h01;
        end
      end else begin
        rd_valid <= 1'b0;
        // Idle read bus shows a changing pattern, never the last word
        rd_data  <= {4{tick_q ^ 32'hA5A5A5A5}};
      end
    end
  end
endmodule : mbt_ctrl_model
`default_nettype wire

// ### bench/test_ddr2_memory_bist.sv
// Purpose: Self-checking bench for the memory self-test engine
// Assumes: Controller model on the far side; short LED counts
// Notes:   A shortened sweep reaches the read phase, the outcome and the LED patterns
`timescale 1ns/10ps
`default_nettype none
module test_ddr2_memory_bist;
  localparam int NCMD  = 12;
  localparam int LIMIT = 20000;
  localparam int SWEEP = 15;
  localparam int NW    = SWEEP + 1;
  localparam int PH    = 8;
  localparam int FS    = 16;
  localparam int FH    = 4;
  logic core_clk, arst_n, dip_sw0, calib_go, slow;
  logic calib_done, app_rdy, app_wdf_rdy, rd_valid;
  logic [127:0] rd_data, app_wdf_data;
  logic app_en, app_wdf_wren, app_wdf_end, test_done, test_fail, status_led;
  logic [2:0]  app_cmd;
  logic [30:0] app_addr;
  logic [30:0]  addr_q[$];
  logic [2:0]   cmd_q[$];
  logic [127:0] data_q[$];
  logic         end_q[$];
  int err_total, cmp_count, cyc;

  mbt_ctrl_model model_u (.core_clk(core_clk), .arst_n(arst_n), .calib_go(calib_go),
    .slow(slow), .app_en(app_en), .app_cmd(app_cmd), .app_addr(app_addr),
    .app_wdf_wren(app_wdf_wren), .app_wdf_end(app_wdf_end), .app_wdf_data(app_wdf_data),
    .calib_done(calib_done), .app_rdy(app_rdy), .app_wdf_rdy(app_wdf_rdy),
    .rd_valid(rd_valid), .rd_data(rd_data));
  mbt_engine #(.PASS_HALF(PH), .FAIL_STEADY(FS), .FAIL_HALF(FH), .SWEEP_LEN(SWEEP)) dut_u (
    .core_clk(core_clk), .arst_n(arst_n), .calib_done(calib_done), .dip_sw0(dip_sw0),
    .app_rdy(app_rdy), .app_wdf_rdy(app_wdf_rdy), .rd_valid(rd_valid), .rd_data(rd_data),
    .app_en(app_en), .app_cmd(app_cmd), .app_addr(app_addr), .app_wdf_wren(app_wdf_wren),
    .app_wdf_end(app_wdf_end), .app_wdf_data(app_wdf_data), .test_done(test_done),
    .test_fail(test_fail), .status_led(status_led));

  initial core_clk = 1'b0;
  always #2.5 core_clk = ~core_clk;

  // Record every command and beat that the controller takes
  always @(posedge core_clk) begin
    if (arst_n === 1'b1) begin
      if (app_en && app_rdy) begin
        addr_q.push_back(app_addr);
        cmd_q.push_back(app_cmd);
      end
      if (app_wdf_wren && app_wdf_rdy) begin
        data_q.push_back(app_wdf_data);
        end_q.push_back(app_wdf_end);
      end
    end
  end

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      err_total++;
      $display("BAD run_length expected below %0d seen %0d", LIMIT, cyc);
      complete_run();
    end
  end

  function automatic logic [63:0] ref_dstep(input logic [63:0] v);
    return {v[62:0], v[63] ^ v[62] ^ v[60] ^ v[59]};
  endfunction : ref_dstep

  function automatic logic [30:0] ref_map(input logic [25:0] a);
    return {3'h0, a[25], a[24:22], a[21:8], a[7:0], 2'h0};
  endfunction : ref_map

  task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Reset with outputs checked while it is held
  task automatic t_reset(input logic dip);
    arst_n   = 1'b0;
    dip_sw0  = dip;
    calib_go = 1'b0;
    addr_q.delete();
    cmd_q.delete();
    data_q.delete();
    end_q.delete();
    repeat (8) @(posedge core_clk);
    chk("app_en", 1'b0, app_en);
    chk("app_wdf_wren", 1'b0, app_wdf_wren);
    chk("test_done", 1'b0, test_done);
    chk("test_fail", 1'b0, test_fail);
    chk("status_led", 1'b0, status_led);
    #1 arst_n = 1'b1;
  endtask : t_reset

  // Calibration pending: engine idle, LED on
  task automatic t_calib_wait();
    repeat (40) @(posedge core_clk);
    #1;
    chk("cmds_before_calib", 0, addr_q.size());
    chk("app_en", 1'b0, app_en);
    chk("status_led", 1'b1, status_led);
  endtask : t_calib_wait

  // Calibration completes: writes start alone in documented order
  task automatic t_write_order(input logic dip, input logic stall);
    logic [25:0] a;
    logic [63:0] lo, hi;
    int k;
    slow     = stall;
    calib_go = 1'b1;
    for (k = 0; k < 3000 && (addr_q.size() < NCMD || data_q.size() < 2 * NCMD); k++)
      @(posedge core_clk);
    #1;
    chk("status_led", 1'b0, status_led);
    chk("test_done", 1'b0, test_done);
    chk("cmd_count_ok", 1, addr_q.size() >= NCMD);
    chk("beat_count_ok", 1, data_q.size() >= 2 * NCMD);
    if (addr_q.size() >= NCMD && data_q.size() >= 2 * NCMD) begin
      a = mbt_pkg::ADDR_SEED;
      for (k = 0; k < NCMD; k++) begin
        chk("app_cmd", mbt_pkg::CMD_WRITE, cmd_q[k]);
        chk("app_addr", (k == 0) ? 31'h0 : ref_map(a), addr_q[k]);
        if (k != 0)
          a = {a[24:0], a[25] ^ a[5] ^ a[1] ^ a[0]};
      end
      lo = mbt_pkg::DATA_SEED_LO;
      hi = mbt_pkg::DATA_SEED_HI;
      for (k = 0; k < 2 * NCMD; k++) begin
        chk("app_wdf_data", {hi, lo ^ {63'h0, dip}}, data_q[k]);
        chk("app_wdf_end", k[0], end_q[k]);
        lo = ref_dstep(lo);
        hi = ref_dstep(hi);
      end
    end
  endtask : t_write_order

  // Run on to the outcome: read order, verdict flags and LED pattern
  task automatic t_read_back(input logic dip);
    logic [25:0] a;
    logic        exp_led;
    int          k;
    int          t;
    for (k = 0; k < 4000 && test_done !== 1'b1; k++) begin
      @(posedge core_clk);
      #1;
    end
    chk("test_done", 1'b1, test_done);
    chk("test_fail", dip, test_fail);
    chk("cmd_total", 2 * NW, addr_q.size());
    chk("beat_total", 2 * NW, data_q.size());
    if (addr_q.size() >= 2 * NW) begin
      a = mbt_pkg::ADDR_SEED;
      for (k = 0; k < NW; k++) begin
        chk("read_cmd", mbt_pkg::CMD_READ, cmd_q[NW + k]);
        chk("read_addr", (k == 0) ? 31'h0 : ref_map(a), addr_q[NW + k]);
        if (k != 0)
          a = {a[24:0], a[25] ^ a[5] ^ a[1] ^ a[0]};
      end
    end
    // Cycle k after the outcome: pass halves of PH, fail FS on then 8 halves of FH
    for (k = 1; k < 64; k++) begin
      @(posedge core_clk);
      #1;
      t = (k + 8 * FH) % (FS + 8 * FH);
      exp_led = dip ? ((t >= 8 * FH) || ((t / FH) % 2 == 1)) : ((k / PH) % 2 == 1);
      chk("status_led", exp_led, status_led);
    end
    chk("app_en_done", 1'b0, app_en);
  endtask : t_read_back

  task automatic complete_run();
    $display("Checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  initial begin
    err_total = 0;
    cmp_count = 0;
    cyc       = 0;
    arst_n    = 1'b0;
    dip_sw0   = 1'b0;
    calib_go  = 1'b0;
    slow      = 1'b0;
    @(posedge core_clk);
    #1;
    t_reset(1'b0);
    t_calib_wait();
    t_write_order(1'b0, 1'b0);
    // Second reset in mid-sweep, error injection and a stalling controller
    t_reset(1'b1);
    t_calib_wait();
    t_write_order(1'b1, 1'b1);
    t_read_back(1'b1);
    // Clean run to a pass outcome
    t_reset(1'b0);
    t_calib_wait();
    t_write_order(1'b0, 1'b0);
    t_read_back(1'b0);
    complete_run();
  end
endmodule : test_ddr2_memory_bist
`default_nettype wire
